// ==== rtl/bstap_top.sv ====
`timescale 1ns/1ps
// Behaviour
// - Boundary-scan port with the standard test logic and register set.
// - Only TMS and TCK steer the state machine; the one other control path is the synchronised RST_N reset.
// - Serial data enters on TDI and leaves on TDO at the TCK rate.
// - Scan registers: pin cell chain, identity, one-bit skip, instruction.
// - Instruction decode picks the test and the register between TDI and TDO.
// - Supports EXTEST, SAMPLE/PRELOAD, IDCODE, BYPASS, CLAMP and HIGHZ.
// - Identity word holds version, part, maker and a fixed one; shifted under IDCODE.
// - Skip path is one bit from TDI to TDO under the bypass instruction.
// - Synchronous sixteen-state controller covering both scan branches.
// - Each transition follows TMS sampled on the rising TCK edge.
// - Separate capture, shift and update branches for data and instruction.
module bstap_top (
    input  wire logic                      CORE_CLK,
    input  wire logic                      RST_N,
    input  wire logic                      TCK,
    input  wire logic                      TMS,
    input  wire logic                      TDI,
    output logic                           TDO,
    output logic                           TDO_OE,
    input  wire logic [bstap_pkg::NPIN-1:0] PAD_IN,
    output logic      [bstap_pkg::NPIN-1:0] PAD_OUT,
    output logic                           PAD_OE,
    input  wire logic [bstap_pkg::NPIN-1:0] CORE_DOUT,
    input  wire logic                      CORE_OE,
    output logic      [bstap_pkg::NPIN-1:0] CORE_DIN
);

    // TCK-domain state
    logic                              tck_rst_n;
    bstap_pkg::bstap_state_t           st_q;
    logic [bstap_pkg::IR_LEN-1:0]      ir_sh_q;
    logic [bstap_pkg::IR_LEN-1:0]      ir_q;
    logic [bstap_pkg::ID_LEN-1:0]      identity_scan_q;
    logic                              skip_path_q;
    bstap_pkg::bstap_cells_t           pin_cell_chain_q;
    bstap_pkg::bstap_cells_t           upd_q;
    logic                              upd_tgl_q;
    logic [1:0]                        mode_q;
    logic [2:0]                        ones_cnt_q;
    bstap_pkg::bstap_cells_t           snap_t;

    // Core-domain state
    bstap_pkg::bstap_cells_t           snap_q;
    bstap_pkg::bstap_cells_t           cells_core_q;
    logic [bstap_pkg::NPIN-1:0]        pad_s;
    logic [1:0]                        mode_s;
    logic                              upd_tgl_s;
    logic                              tgl_seen_q;

    // Decoded controls
    wire bstap_pkg::bstap_dr_t dr_sel     = bstap_pkg::bstap_dr_sel(ir_q);
    wire logic in_tlr        = (st_q == bstap_pkg::ST_TLR);
    wire logic in_cap_dr     = (st_q == bstap_pkg::ST_CAPTURE_DR);
    wire logic in_shift_dr   = (st_q == bstap_pkg::ST_SHIFT_DR);
    wire logic in_upd_dr     = (st_q == bstap_pkg::ST_UPDATE_DR);
    wire logic in_cap_ir     = (st_q == bstap_pkg::ST_CAPTURE_IR);
    wire logic in_shift_ir   = (st_q == bstap_pkg::ST_SHIFT_IR);
    wire logic in_upd_ir     = (st_q == bstap_pkg::ST_UPDATE_IR);
    wire logic in_shift      = in_shift_dr | in_shift_ir;
    wire logic sel_id        = (dr_sel == bstap_pkg::DR_ID);
    wire logic sel_chain     = (dr_sel == bstap_pkg::DR_CHAIN);
    wire logic sel_skip      = (dr_sel == bstap_pkg::DR_SKIP);

    // Pins are driven from the update cells under EXTEST and CLAMP
    wire logic drive_cells_d = (ir_q == bstap_pkg::INS_EXTEST) | (ir_q == bstap_pkg::INS_CLAMP);
    wire logic float_d       = (ir_q == bstap_pkg::INS_HIGHZ);

    // Serial output select
    wire logic dr_ser = sel_id    ? identity_scan_q[0] :
                        sel_chain ? pin_cell_chain_q[0] : skip_path_q;
    wire logic ser_out = in_shift_ir ? ir_sh_q[0] : dr_ser;

    // Reset reaches the TCK domain through a synchroniser
    bstap_sync #(.W(1)) u_rst_sync (
        .clk (TCK),
        .d   (RST_N),
        .q   (tck_rst_n)
    );

    // Controller sees only TMS and TCK besides reset
    bstap_fsm u_fsm (
        .tck   (TCK),
        .rst_n (tck_rst_n),
        .tms   (TMS),
        .st_q  (st_q)
    );

    // Core snapshot sampled into the capture domain
    bstap_sync #(.W(bstap_pkg::CHAIN_LEN)) u_snap_sync (
        .clk (TCK),
        .d   (snap_q),
        .q   (snap_t)
    );

    // Instruction shift and capture
    always_ff @(posedge TCK)
    begin
        if (in_cap_ir)
            ir_sh_q <= bstap_pkg::IR_CAPTURE;
        else if (in_shift_ir)
            ir_sh_q <= {TDI, ir_sh_q[bstap_pkg::IR_LEN-1:1]};
    end

    // Active instruction; reset state falls back to identity
    always_ff @(posedge TCK)
    begin
        if (!tck_rst_n || in_tlr)
            ir_q <= bstap_pkg::IR_RESET;
        else if (in_upd_ir)
            ir_q <= ir_sh_q;
    end

    // Identity register
    always_ff @(posedge TCK)
    begin
        if (in_cap_dr && sel_id)
            identity_scan_q <= bstap_pkg::ID_WORD;
        else if (in_shift_dr && sel_id)
            identity_scan_q <= {TDI, identity_scan_q[bstap_pkg::ID_LEN-1:1]};
    end

    // Single-bit skip path
    always_ff @(posedge TCK)
    begin
        if (in_cap_dr && sel_skip)
            skip_path_q <= bstap_pkg::SKIP_CAPTURE;
        else if (in_shift_dr && sel_skip)
            skip_path_q <= TDI;
    end

    // Pin cell chain: capture, shift
    always_ff @(posedge TCK)
    begin
        if (in_cap_dr && sel_chain)
            pin_cell_chain_q <= snap_t;
        else if (in_shift_dr && sel_chain)
            pin_cell_chain_q <= {TDI, pin_cell_chain_q[bstap_pkg::CHAIN_LEN-1:1]};
    end

    // Update cells, toggle tells the core a new word is stable
    always_ff @(posedge TCK)
    begin
        if (!tck_rst_n)
        begin
            upd_q     <= bstap_pkg::CELL_RESET;
            upd_tgl_q <= 1'h0;
        end
        else if (in_upd_dr && sel_chain)
        begin
            upd_q     <= pin_cell_chain_q;
            upd_tgl_q <= ~upd_tgl_q;
        end
    end

    // Mode levels registered so the crossing sees no decode glitch
    always_ff @(posedge TCK)
    begin
        if (!tck_rst_n)
            mode_q <= 2'h0;
        else
            mode_q <= {float_d, drive_cells_d};
    end

    // TDO launched on the falling edge, floated outside shift states
    always_ff @(negedge TCK)
    begin
        if (!tck_rst_n)
        begin
            TDO    <= 1'h0;
            TDO_OE <= 1'h0;
        end
        else
        begin
            TDO    <= ser_out;
            TDO_OE <= in_shift;
        end
    end

    // Counts consecutive high TMS edges, read only by a check
    always_ff @(posedge TCK)
    begin
        if (!tck_rst_n || !TMS)
            ones_cnt_q <= 3'h0;
        else if (ones_cnt_q != bstap_pkg::TMS_RESET_EDGES)
            ones_cnt_q <= ones_cnt_q + 3'h1;
    end

    // Pads are pins, synchronised before use
    bstap_sync #(.W(bstap_pkg::NPIN)) u_pad_sync (
        .clk (CORE_CLK),
        .d   (PAD_IN),
        .q   (pad_s)
    );

    // Mode levels into the core clock
    bstap_sync #(.W(2)) u_mode_sync (
        .clk (CORE_CLK),
        .d   (mode_q),
        .q   (mode_s)
    );

    // Update toggle into the core clock
    bstap_sync #(.W(1)) u_tgl_sync (
        .clk (CORE_CLK),
        .d   (upd_tgl_q),
        .q   (upd_tgl_s)
    );

    // Normal function path: pins reach the core only through the synchroniser
    assign CORE_DIN = pad_s;

    // Snapshot of what the pins see and what the core drives
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
            snap_q <= bstap_pkg::CELL_RESET;
        else
            snap_q <= '{oe: CORE_OE, dout: CORE_DOUT, din: pad_s};
    end

    // Take the update word once its toggle has crossed; word is stable
    // by then because it only changes on the next update-dr
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            tgl_seen_q   <= 1'h0;
            cells_core_q <= bstap_pkg::CELL_RESET;
        end
        else if (upd_tgl_s != tgl_seen_q)
        begin
            tgl_seen_q   <= upd_tgl_s;
            cells_core_q <= upd_q;
        end
    end

    // Pin drivers: float wins, then scan cells, then normal function
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            PAD_OUT <= '0;
            PAD_OE  <= 1'h0;
        end
        else if (mode_s[1])
        begin
            PAD_OUT <= CORE_DOUT;
            PAD_OE  <= 1'h0;
        end
        else if (mode_s[0])
        begin
            PAD_OUT <= cells_core_q.dout;
            PAD_OE  <= cells_core_q.oe;
        end
        else
        begin
            PAD_OUT <= CORE_DOUT;
            PAD_OE  <= CORE_OE;
        end
    end

    // Scan path checks, on rising TCK except the two TDO checks on falling TCK
    chk_tms_reset_walk: assert property (@(posedge TCK) disable iff (!tck_rst_n)
        (ones_cnt_q == bstap_pkg::TMS_RESET_EDGES) |-> in_tlr)
        else $error("five high TMS edges did not reach reset");

    chk_reset_selects_id: assert property (@(posedge TCK) disable iff (!tck_rst_n)
        in_tlr |=> (ir_q == bstap_pkg::INS_IDCODE && sel_id))
        else $error("reset did not select identity");

    chk_id_capture: assert property (@(posedge TCK) disable iff (!tck_rst_n)
        (in_cap_dr && sel_id) |=> identity_scan_q == bstap_pkg::ID_WORD)
        else $error("identity word not captured");

    chk_skip_one_bit: assert property (@(posedge TCK) disable iff (!tck_rst_n)
        (in_shift_dr && ir_q == bstap_pkg::INS_BYPASS) |=> skip_path_q == $past(TDI))
        else $error("skip path is not one bit");

    chk_ir_capture: assert property (@(posedge TCK) disable iff (!tck_rst_n)
        in_cap_ir |=> ir_sh_q == bstap_pkg::IR_CAPTURE)
        else $error("instruction capture value wrong");

    chk_ir_update: assert property (@(posedge TCK) disable iff (!tck_rst_n)
        in_upd_ir |=> ir_q == $past(ir_sh_q))
        else $error("instruction not updated");

    chk_ir_shift_in: assert property (@(posedge TCK) disable iff (!tck_rst_n)
        in_shift_ir |=> ir_sh_q[bstap_pkg::IR_LEN-1] == $past(TDI))
        else $error("TDI not shifted into instruction");

    chk_skip_capture: assert property (@(posedge TCK) disable iff (!tck_rst_n)
        (in_cap_dr && sel_skip) |=> skip_path_q == bstap_pkg::SKIP_CAPTURE)
        else $error("skip path did not capture its fixed value");

    chk_snap_capture: assert property (@(posedge TCK) disable iff (!tck_rst_n)
        (in_cap_dr && sel_chain) |=> pin_cell_chain_q == $past(snap_t))
        else $error("pin cells did not capture the snapshot");

    chk_chain_shift: assert property (@(posedge TCK) disable iff (!tck_rst_n)
        (in_shift_dr && sel_chain) |=> pin_cell_chain_q[bstap_pkg::CHAIN_LEN-1] == $past(TDI))
        else $error("TDI not shifted into pin cells");

    chk_id_shift: assert property (@(posedge TCK) disable iff (!tck_rst_n)
        (in_shift_dr && sel_id) |=> identity_scan_q[bstap_pkg::ID_LEN-1] == $past(TDI))
        else $error("TDI not shifted into identity register");

    chk_chain_update: assert property (@(posedge TCK) disable iff (!tck_rst_n)
        (in_upd_dr && sel_chain) |=> upd_q == $past(pin_cell_chain_q))
        else $error("update cells did not take the chain");

    chk_ir_hold: assert property (@(posedge TCK) disable iff (!tck_rst_n)
        !(in_upd_ir || in_tlr) |=> $stable(ir_q))
        else $error("instruction changed outside update-ir");

    chk_tlr_hold: assert property (@(posedge TCK) disable iff (!tck_rst_n)
        (in_tlr && TMS) |=> in_tlr)
        else $error("reset state left with TMS high");

    // Enable is unknown until the synchronised reset has been seen once
    chk_tdo_float: assert property (@(negedge TCK) disable iff (!tck_rst_n)
        $past(tck_rst_n) |-> TDO_OE == $past(in_shift))
        else $error("TDO enable does not follow shift state");

    chk_tdo_value: assert property (@(negedge TCK) disable iff (!tck_rst_n)
        $past(in_shift) |-> TDO == $past(ser_out))
        else $error("TDO does not carry the selected register");

    // Pad checks on the core clock
    chk_highz_pads: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        mode_s[1] |=> !PAD_OE)
        else $error("pads driven under highz");

    chk_extest_pads: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (mode_s == 2'h1) |=> (PAD_OUT == $past(cells_core_q.dout) && PAD_OE == $past(cells_core_q.oe)))
        else $error("pads not driven from update cells");

    chk_normal_pads: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (mode_s == 2'h0) |=> (PAD_OUT == $past(CORE_DOUT) && PAD_OE == $past(CORE_OE)))
        else $error("pads not on normal function");

endmodule : bstap_top

// ==== include/bstap_pkg.sv ====
package bstap_pkg;

    // Scan register geometry
    localparam int IR_LEN    = 4;
    localparam int ID_LEN    = 32;
    localparam int NPIN      = 4;
    localparam int CHAIN_LEN = 2 * NPIN + 1;

    // Instruction codes; all ones must stay the skip path
    localparam logic [IR_LEN-1:0] INS_EXTEST = 4'h0;
    localparam logic [IR_LEN-1:0] INS_SAMPLE = 4'h1;
    localparam logic [IR_LEN-1:0] INS_IDCODE = 4'h2;
    localparam logic [IR_LEN-1:0] INS_CLAMP  = 4'h3;
    localparam logic [IR_LEN-1:0] INS_HIGHZ  = 4'h4;
    localparam logic [IR_LEN-1:0] INS_BYPASS = 4'hf;

    // Values loaded at capture and after reset
    localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1;
    localparam logic [IR_LEN-1:0] IR_RESET   = INS_IDCODE;
    localparam logic              SKIP_CAPTURE = 1'h0;

    // Identity fields; the values are arbitrary
    localparam logic [3:0]  ID_VERSION = 4'h1;
    localparam logic [15:0] ID_PART    = 16'h5a5a;
    localparam logic [10:0] ID_MANUF   = 11'h123;
    localparam logic        ID_FIXED   = 1'h1;
    localparam logic [ID_LEN-1:0] ID_WORD = {ID_VERSION, ID_PART, ID_MANUF, ID_FIXED};

    // Consecutive high TMS edges that always reach test-logic-reset
    localparam logic [2:0] TMS_RESET_EDGES = 3'h5;

    typedef enum logic [3:0] {
        ST_TLR, ST_IDLE,
        ST_SEL_DR, ST_CAPTURE_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPDATE_DR,
        ST_SEL_IR, ST_CAPTURE_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPDATE_IR
    } bstap_state_t;

    typedef enum logic [1:0] {DR_SKIP, DR_ID, DR_CHAIN} bstap_dr_t;

    // One boundary snapshot: output enable cell, output cells, input cells
    typedef struct packed {
        logic            oe;
        logic [NPIN-1:0] dout;
        logic [NPIN-1:0] din;
    } bstap_cells_t;

    localparam bstap_cells_t CELL_RESET = '0;

    // Data register placed between TDI and TDO for an instruction
    function automatic bstap_dr_t bstap_dr_sel(input logic [IR_LEN-1:0] ins);
        case (ins)
            INS_EXTEST, INS_SAMPLE: bstap_dr_sel = DR_CHAIN;
            INS_IDCODE:             bstap_dr_sel = DR_ID;
            default:                bstap_dr_sel = DR_SKIP;
        endcase
    endfunction : bstap_dr_sel

endpackage : bstap_pkg

// ==== rtl/bstap_sync.sv ====
`timescale 1ns/1ps
module bstap_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    // Two stages; the first is read only by the second
    always_ff @(posedge clk)
    begin
        meta_q <= d;
        q      <= meta_q;
    end
endmodule : bstap_sync

// ==== rtl/bstap_fsm.sv ====
`timescale 1ns/1ps
module bstap_fsm (
    input  wire logic          tck,
    input  wire logic          rst_n,
    input  wire logic          tms,
    output bstap_pkg::bstap_state_t st_q
);
    bstap_pkg::bstap_state_t st_d;

    // Standard sixteen-state graph, TMS is the only steering input
    always_comb
    begin
        case (st_q)
            bstap_pkg::ST_TLR:        st_d = tms ? bstap_pkg::ST_TLR       : bstap_pkg::ST_IDLE;
            bstap_pkg::ST_IDLE:       st_d = tms ? bstap_pkg::ST_SEL_DR    : bstap_pkg::ST_IDLE;
            bstap_pkg::ST_SEL_DR:     st_d = tms ? bstap_pkg::ST_SEL_IR    : bstap_pkg::ST_CAPTURE_DR;
            bstap_pkg::ST_CAPTURE_DR: st_d = tms ? bstap_pkg::ST_EXIT1_DR  : bstap_pkg::ST_SHIFT_DR;
            bstap_pkg::ST_SHIFT_DR:   st_d = tms ? bstap_pkg::ST_EXIT1_DR  : bstap_pkg::ST_SHIFT_DR;
            bstap_pkg::ST_EXIT1_DR:   st_d = tms ? bstap_pkg::ST_UPDATE_DR : bstap_pkg::ST_PAUSE_DR;
            bstap_pkg::ST_PAUSE_DR:   st_d = tms ? bstap_pkg::ST_EXIT2_DR  : bstap_pkg::ST_PAUSE_DR;
            bstap_pkg::ST_EXIT2_DR:   st_d = tms ? bstap_pkg::ST_UPDATE_DR : bstap_pkg::ST_SHIFT_DR;
            bstap_pkg::ST_UPDATE_DR:  st_d = tms ? bstap_pkg::ST_SEL_DR    : bstap_pkg::ST_IDLE;
            bstap_pkg::ST_SEL_IR:     st_d = tms ? bstap_pkg::ST_TLR       : bstap_pkg::ST_CAPTURE_IR;
            bstap_pkg::ST_CAPTURE_IR: st_d = tms ? bstap_pkg::ST_EXIT1_IR  : bstap_pkg::ST_SHIFT_IR;
            bstap_pkg::ST_SHIFT_IR:   st_d = tms ? bstap_pkg::ST_EXIT1_IR  : bstap_pkg::ST_SHIFT_IR;
            bstap_pkg::ST_EXIT1_IR:   st_d = tms ? bstap_pkg::ST_UPDATE_IR : bstap_pkg::ST_PAUSE_IR;
            bstap_pkg::ST_PAUSE_IR:   st_d = tms ? bstap_pkg::ST_EXIT2_IR  : bstap_pkg::ST_PAUSE_IR;
            bstap_pkg::ST_EXIT2_IR:   st_d = tms ? bstap_pkg::ST_UPDATE_IR : bstap_pkg::ST_SHIFT_IR;
            bstap_pkg::ST_UPDATE_IR:  st_d = tms ? bstap_pkg::ST_SEL_DR    : bstap_pkg::ST_IDLE;
            default:                  st_d = bstap_pkg::ST_TLR;
        endcase
    end

    // Advances on every rising TCK edge
    always_ff @(posedge tck)
    begin
        if (!rst_n)
            st_q <= bstap_pkg::ST_TLR;
        else
            st_q <= st_d;
    end

    chk_shift_dr_hold: assert property (@(posedge tck) disable iff (!rst_n)
        (st_q == bstap_pkg::ST_SHIFT_DR && !tms) |=> st_q == bstap_pkg::ST_SHIFT_DR)
        else $error("shift-dr left with TMS low");

    chk_ir_branch_walk: assert property (@(posedge tck) disable iff (!rst_n)
        (st_q == bstap_pkg::ST_SEL_DR && tms) ##1 !tms |=> st_q == bstap_pkg::ST_CAPTURE_IR)
        else $error("instruction branch not entered");

    chk_update_exit: assert property (@(posedge tck) disable iff (!rst_n)
        (st_q == bstap_pkg::ST_UPDATE_DR) |=> (st_q == bstap_pkg::ST_SEL_DR || st_q == bstap_pkg::ST_IDLE))
        else $error("bad successor of update-dr");
endmodule : bstap_fsm

// ==== tb/bstap_ctl_model.sv ====
`timescale 1ns/1ps
module bstap_ctl_model (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    logic [32:0] res;
    logic        oe_ok;
    logic        smp_tdo;
    logic        smp_oe;
    event        got;

    // Test clock stands low between frames; TMS high parks the port in reset
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One TCK period; lines change just after the falling edge
    task automatic step(input logic m, input logic d);
        #1;
        tms = m;
        tdi = d;
        #31 tck = 1'b1;
        // A released TDO floats; read it as the inverse so a missing enable shows
        smp_tdo = tdo_oe ? tdo : ~tdo;
        smp_oe  = tdo_oe;
        #32 tck = 1'b0;
    endtask : step

    // Free running TCK with TMS held high
    task automatic hold_reset(input int n);
        repeat (n) step(1'b1, 1'b0);
    endtask : hold_reset

    // Shift n bits LSB first, leave through exit1 and update to idle
    task automatic shift(input int n, input logic [32:0] din);
        res   = '0;
        oe_ok = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i]);
            res[i] = smp_tdo;
            oe_ok  = oe_ok & smp_oe;
        end
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        -> got;
    endtask : shift

    // Instruction scan from idle
    task automatic ir_scan(input logic [3:0] ins);
        step(1'b1, 1'b0);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        shift(4, {29'h0, ins});
    endtask : ir_scan

    // Data scan from idle, always 33 bits
    task automatic dr_scan(input logic [32:0] din);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        shift(33, din);
    endtask : dr_scan
endmodule : bstap_ctl_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    logic        core_clk;
    logic        rst_n;
    logic        tck;
    logic        tms;
    logic        tdi;
    logic        tdo;
    logic        tdo_oe;
    logic [3:0]  pad_in;
    logic [3:0]  pad_out;
    logic        pad_oe;
    logic [3:0]  core_dout;
    logic        core_oe;
    logic [3:0]  core_din;
    logic [32:0] exp_q[$];
    logic [32:0] exp_v;
    logic [32:0] din;
    logic [8:0]  cap;
    logic [8:0]  cells;
    int          err_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          seed = 38833;

    // Every instruction plus one undefined code, preload first
    localparam logic [3:0] CODES [7] = '{bstap_pkg::INS_SAMPLE, bstap_pkg::INS_EXTEST, bstap_pkg::INS_CLAMP,
        bstap_pkg::INS_HIGHZ, bstap_pkg::INS_IDCODE, bstap_pkg::INS_BYPASS, 4'h7};

    bstap_ctl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

    bstap_top dut (
        .CORE_CLK  (core_clk),
        .RST_N     (rst_n),
        .TCK       (tck),
        .TMS       (tms),
        .TDI       (tdi),
        .TDO       (tdo),
        .TDO_OE    (tdo_oe),
        .PAD_IN    (pad_in),
        .PAD_OUT   (pad_out),
        .PAD_OE    (pad_oe),
        .CORE_DOUT (core_dout),
        .CORE_OE   (core_oe),
        .CORE_DIN  (core_din)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic summarize();
        $display("Compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Serial word expected out of the register chosen by an instruction
    function automatic logic [32:0] dr_exp(input logic [3:0] ins, input logic [32:0] d, input logic [8:0] c);
        case (ins)
            bstap_pkg::INS_EXTEST, bstap_pkg::INS_SAMPLE: dr_exp = {d[23:0], c};
            bstap_pkg::INS_IDCODE:                        dr_exp = {d[0], bstap_pkg::ID_WORD};
            default:                                      dr_exp = {d[31:0], 1'b0};
        endcase
    endfunction : dr_exp

    // Hang guard; a normal run needs well under a thousand cycles
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_count++;
            summarize();
        end
    end

    // Oldest note against every finished scan
    initial
    begin
        forever
        begin
            @(ctl.got);
            exp_v = exp_q.pop_front();
            check("scan_out", ctl.res, exp_v);
        end
    end

    initial
    begin
        rst_n     = 1'b0;
        pad_in    = 4'h0;
        core_dout = 4'h0;
        core_oe   = 1'b0;
        cells     = 9'h0;
        // TCK runs through reset so the synchronised reset takes
        fork
            ctl.hold_reset(8);
            begin
                repeat (2) @(posedge core_clk);
                rst_n <= 1'b1;
            end
        join
        ctl.hold_reset(3);
        ctl.step(1'b0, 1'b0);
        din = 33'({$random(seed), $random(seed)});
        exp_q.push_back(dr_exp(bstap_pkg::INS_IDCODE, din, 9'h0));
        ctl.dr_scan(din);
        for (int k = 0; k < 7; k++)
        begin
            @(posedge core_clk);
            pad_in    <= 4'($random(seed));
            core_dout <= 4'($random(seed));
            core_oe   <= 1'($random(seed));
            repeat (10) @(posedge core_clk);
            cap = {core_oe, core_dout, pad_in};
            din = 33'({$random(seed), $random(seed)});
            exp_q.push_back(33'(bstap_pkg::IR_CAPTURE));
            ctl.ir_scan(CODES[k]);
            exp_q.push_back(dr_exp(CODES[k], din, cap));
            ctl.dr_scan(din);
            // Update cells follow every chain scan, kept across other codes
            if (CODES[k] == bstap_pkg::INS_EXTEST || CODES[k] == bstap_pkg::INS_SAMPLE)
                cells = din[32:24];
            repeat (10) @(posedge core_clk);
            @(negedge core_clk);
            check("tdo_oe_shift", 33'(ctl.oe_ok), 33'h1);
            check("tdo_oe_idle", 33'(tdo_oe), 33'h0);
            check("core_din", 33'(core_din), 33'(pad_in));
            if (CODES[k] == bstap_pkg::INS_EXTEST || CODES[k] == bstap_pkg::INS_CLAMP)
            begin
                check("pad_out", 33'(pad_out), 33'(cells[7:4]));
                check("pad_oe", 33'(pad_oe), 33'(cells[8]));
            end
            else
            begin
                check("pad_out", 33'(pad_out), 33'(core_dout));
                check("pad_oe", 33'(pad_oe), (CODES[k] == bstap_pkg::INS_HIGHZ) ? 33'h0 : 33'(core_oe));
            end
        end
        // From shift-DR, exactly five high TMS edges must reach reset
        ctl.step(1'b1, 1'b0);
        ctl.step(1'b0, 1'b0);
        ctl.step(1'b0, 1'b0);
        ctl.hold_reset(5);
        ctl.step(1'b0, 1'b0);
        din = 33'({$random(seed), $random(seed)});
        exp_q.push_back(dr_exp(bstap_pkg::INS_IDCODE, din, 9'h0));
        ctl.dr_scan(din);
        repeat (4) @(posedge core_clk);
        check("notes_left", 33'(exp_q.size()), 33'h0);
        summarize();
    end
endmodule : tb_top
